// *** rtl/scl_cfg.svh ***
// constants for the serial control line decoder
`ifndef SCL_CFG_SVH
`define SCL_CFG_SVH
`define SCL_NCHAN        8
`define SCL_REG_WR0      3'h0
`define SCL_REG_WR2      3'h2
`define SCL_REG_WR5      3'h5
`define SCL_REG_RR0      3'h0
`define SCL_REG_RR1      3'h1
`define SCL_REG_RR2      3'h2
`define SCL_PTR_ZERO     3'h0
`define SCL_WR5_RESET    8'h00
`define SCL_BYTE_ZERO    8'h00
`define SCL_BIT_SED      1
`define SCL_BIT_DIFF     7
`define SCL_BIT_LAMP     1
`define SCL_BIT_LOOP     7
`define SCL_CMD_MSB      5
`define SCL_CMD_LSB      3
`define SCL_CMD_CHRESET  3'h3
`define SCL_CH_C0A       3'h0
`define SCL_CH_C0B       3'h1
`define SCL_CH_C1B       3'h3
`define SCL_CH_BSEL      0
`define SCL_VEC_MSB      3
`define SCL_VEC_LSB      1
`define SCL_VEC_IDLE     3'h3
`define SCL_RR0_TXEMPTY  2
`define SCL_RR0_RXLVL    4
`define SCL_RR1_ALLSENT  0
`endif

// *** rtl/scl_decode.sv ***
// serial controller register port and board control line decode
`timescale 1ns/1ns
`include "scl_cfg.svh"
module scl_decode (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic [2:0]           cpu_addr,
    input  wire scl_pkg::scl_byte_type cpu_data_in,
    output scl_pkg::scl_byte_type     cpu_data_out,
    output logic                      cpu_data_oe,
    input  wire logic                 cpu_iorq_n,
    input  wire logic                 cpu_rd_n,
    input  wire logic                 cpu_wr_n,
    input  wire logic                 cpu_m1_n,
    input  wire logic [7:0]           chan_txd,
    input  wire logic [7:0]           line_rxd,
    output logic [7:0]                chan_rxd,
    output logic [7:0]                se_txd,
    output logic [7:0]                diff_txd,
    output logic [7:0]                diff_txd_oe,
    output logic                      single_ended_driver_enable_n,
    output logic                      differential_driver_enable,
    output logic                      lamp_on,
    output logic                      loopback_n,
    output logic                      line_rx_enable
);
    import scl_pkg::*;

    // bus pin synchronisers
    logic [2:0]   addr_m_q;
    logic [2:0]   addr_s_q;
    scl_byte_type data_m_q;
    scl_byte_type data_s_q;
    logic [3:0]   strb_m_q;
    logic [3:0]   strb_s_q;
    logic [7:0]   rxd_m_q;
    logic [7:0]   rxd_s_q;

    // decoded access state
    logic          wr_q;
    logic          rd_act;
    logic          wr_act;
    logic          wr_start;
    logic          rd_start;
    scl_state_type state_q;
    scl_state_type state_d;
    scl_idx_type   acc_chan_q;
    scl_idx_type   acc_reg_q;
    scl_idx_type   ptr_q [0:`SCL_NCHAN-1];
    scl_byte_type  wr5_q [0:`SCL_NCHAN-1];
    scl_byte_type  read_val;

    scl_mem_if mem_bus ();

    // register index pointed at by a channel
    function automatic scl_idx_type ptr_of(input scl_idx_type ch);
        return ptr_q[ch];
    endfunction

    // one bit of a channel's transmit control register
    function automatic logic wr5_bit(input scl_idx_type ch, input int unsigned pos);
        return wr5_q[ch][pos];
    endfunction

    // two flip-flops on every cpu pin
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            addr_m_q <= 3'h0;
            addr_s_q <= 3'h0;
            data_m_q <= `SCL_BYTE_ZERO;
            data_s_q <= `SCL_BYTE_ZERO;
            strb_m_q <= 4'hf;
            strb_s_q <= 4'hf;
        end else begin
            addr_m_q <= cpu_addr;
            addr_s_q <= addr_m_q;
            data_m_q <= cpu_data_in;
            data_s_q <= data_m_q;
            strb_m_q <= {cpu_m1_n, cpu_iorq_n, cpu_rd_n, cpu_wr_n};
            strb_s_q <= strb_m_q;
        end
    end

    // two flip-flops on the line receivers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rxd_m_q <= 8'hff;
            rxd_s_q <= 8'hff;
        end else begin
            rxd_m_q <= line_rxd;
            rxd_s_q <= rxd_m_q;
        end
    end

    // io cycles only; iorq with m1 is an acknowledge and is ignored
    assign rd_act   = strb_s_q[3] & ~strb_s_q[2] & ~strb_s_q[1];
    assign wr_act   = strb_s_q[3] & ~strb_s_q[2] & ~strb_s_q[0];
    assign wr_start = wr_act & (state_q == SCL_ST_IDLE);
    assign rd_start = rd_act & (state_q == SCL_ST_IDLE);

    // access sequencer
    always_comb begin
        state_d = state_q;
        case (state_q)
            SCL_ST_IDLE: begin
                if (rd_act) begin
                    state_d = SCL_ST_FETCH;
                end else if (wr_act) begin
                    state_d = SCL_ST_END;
                end
            end
            SCL_ST_FETCH: begin
                state_d = SCL_ST_DRIVE;
            end
            SCL_ST_DRIVE: begin
                if (!rd_act) begin
                    state_d = SCL_ST_IDLE;
                end
            end
            SCL_ST_END: begin
                if (!wr_act) begin
                    state_d = SCL_ST_IDLE;
                end
            end
            default: begin
                state_d = SCL_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= SCL_ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // latch channel and register at access start
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            acc_chan_q <= `SCL_PTR_ZERO;
            acc_reg_q  <= `SCL_PTR_ZERO;
        end else if (rd_start || wr_start) begin
            acc_chan_q <= addr_s_q;
            acc_reg_q  <= ptr_of(addr_s_q);
        end
    end

    // pointer: set by a reg 0 write, back to zero after any other access
    genvar gi;
    generate
        for (gi = 0; gi < `SCL_NCHAN; gi++) begin : g_chan
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    ptr_q[gi] <= `SCL_PTR_ZERO;
                end else if ((rd_start || wr_start) && addr_s_q == scl_idx_type'(gi)) begin
                    if (wr_start && ptr_of(addr_s_q) == `SCL_REG_WR0) begin
                        ptr_q[gi] <= data_s_q[2:0];
                    end else begin
                        ptr_q[gi] <= `SCL_PTR_ZERO;
                    end
                end
            end

            // transmit control; channel reset command clears it
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    wr5_q[gi] <= `SCL_WR5_RESET;
                end else if (wr_start && addr_s_q == scl_idx_type'(gi)) begin
                    if (ptr_of(addr_s_q) == `SCL_REG_WR5) begin
                        wr5_q[gi] <= data_s_q;
                    end else if (ptr_of(addr_s_q) == `SCL_REG_WR0 &&
                                 data_s_q[`SCL_CMD_MSB:`SCL_CMD_LSB] == `SCL_CMD_CHRESET) begin
                        wr5_q[gi] <= `SCL_WR5_RESET;
                    end
                end
            end
        end
    endgenerate

    // memory port: every write register, sync chars in 6 and 7
    assign mem_bus.we    = wr_start;
    assign mem_bus.waddr = {addr_s_q, ptr_of(addr_s_q)};
    assign mem_bus.wdata = data_s_q;
    // vector is always fetched from channel B of the pair; the held address
    // lets the registered read settle before the fetch state uses it
    assign mem_bus.raddr = {addr_s_q[2:1], 1'b1, `SCL_REG_WR2};

    scl_regmem u_regmem (
        .clk  (clk),
        .port (mem_bus.ctrl)
    );

    // read register contents
    always_comb begin
        read_val = `SCL_BYTE_ZERO;
        case (acc_reg_q)
            `SCL_REG_RR0: begin
                read_val[`SCL_RR0_TXEMPTY] = 1'b1;
                read_val[`SCL_RR0_RXLVL]   = chan_rxd[acc_chan_q];
            end
            `SCL_REG_RR1: begin
                read_val[`SCL_RR1_ALLSENT] = 1'b1;
            end
            `SCL_REG_RR2: begin
                if (acc_chan_q[`SCL_CH_BSEL]) begin
                    read_val = mem_bus.rdata;
                    read_val[`SCL_VEC_MSB:`SCL_VEC_LSB] = `SCL_VEC_IDLE;
                end
            end
            default: begin
                read_val = `SCL_BYTE_ZERO;
            end
        endcase
    end

    // data bus drive during a read
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cpu_data_out <= `SCL_BYTE_ZERO;
            cpu_data_oe  <= 1'b0;
        end else if (state_q == SCL_ST_FETCH) begin
            cpu_data_out <= read_val;
            cpu_data_oe  <= 1'b1;
        end else if (state_q == SCL_ST_DRIVE && !rd_act) begin
            cpu_data_oe  <= 1'b0;
        end
    end

    // board control lines
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            single_ended_driver_enable_n <= 1'b1;
            differential_driver_enable   <= 1'b1;
            lamp_on                      <= 1'b1;
            loopback_n                   <= 1'b1;
            line_rx_enable               <= 1'b1;
        end else begin
            single_ended_driver_enable_n <= ~wr5_bit(`SCL_CH_C0A, `SCL_BIT_SED);
            differential_driver_enable   <= ~wr5_bit(`SCL_CH_C0B, `SCL_BIT_DIFF);
            lamp_on <= ~wr5_bit(`SCL_CH_C0B, `SCL_BIT_LAMP) &
                       ~wr5_bit(`SCL_CH_C1B, `SCL_BIT_LAMP);
            loopback_n     <= ~wr5_bit(`SCL_CH_C0A, `SCL_BIT_LOOP);
            line_rx_enable <= ~wr5_bit(`SCL_CH_C0A, `SCL_BIT_LOOP);
        end
    end

    // per-channel line path; one loopback for all channels
    generate
        for (gi = 0; gi < `SCL_NCHAN; gi++) begin : g_line
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    chan_rxd[gi]    <= 1'b1;
                    se_txd[gi]      <= 1'b1;
                    diff_txd[gi]    <= 1'b1;
                    diff_txd_oe[gi] <= 1'b1;
                end else begin
                    if (wr5_bit(`SCL_CH_C0A, `SCL_BIT_LOOP)) begin
                        chan_rxd[gi] <= chan_txd[gi];
                    end else begin
                        chan_rxd[gi] <= rxd_s_q[gi];
                    end
                    // mark while the single-ended drivers are off
                    se_txd[gi]      <= wr5_bit(`SCL_CH_C0A, `SCL_BIT_SED) ?
                                       chan_txd[gi] : 1'b1;
                    diff_txd[gi]    <= chan_txd[gi];
                    diff_txd_oe[gi] <= ~wr5_bit(`SCL_CH_C0B, `SCL_BIT_DIFF);
                end
            end
        end
    endgenerate
endmodule // scl_decode

// *** rtl/scl_mem_if.sv ***
// carrier between decoder and register memory
`timescale 1ns/1ns
interface scl_mem_if;
    import scl_pkg::*;
    logic          we;
    scl_maddr_type waddr;
    scl_byte_type  wdata;
    scl_maddr_type raddr;
    scl_byte_type  rdata;
    modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// *** rtl/scl_pkg.sv ***
// types shared by the serial control line decoder
package scl_pkg;
    typedef logic [7:0] scl_byte_type;
    typedef logic [2:0] scl_idx_type;
    typedef logic [5:0] scl_maddr_type;
    typedef enum logic [3:0] {
        SCL_ST_IDLE  = 4'b0001,
        SCL_ST_FETCH = 4'b0010,
        SCL_ST_DRIVE = 4'b0100,
        SCL_ST_END   = 4'b1000
    } scl_state_type;
endpackage

// *** rtl/scl_regmem.sv ***
// per-channel write register storage, registered read
`timescale 1ns/1ns
module scl_regmem
    import scl_pkg::*;
(
    input wire logic clk,
    scl_mem_if.mem   port
);
    scl_byte_type mem_q [0:63];
    scl_byte_type rdata_q;

    // write port
    always_ff @(posedge clk) begin
        if (port.we) begin
            mem_q[port.waddr] <= port.wdata;
        end
    end

    // read data from a register
    always_ff @(posedge clk) begin
        rdata_q <= mem_q[port.raddr];
    end

    assign port.rdata = rdata_q;
endmodule // scl_regmem

// *** tb/scl_decode_assertions.sv ***
// checker on the decoder's control lines and line paths
`timescale 1ns/1ns
module scl_decode_assertions (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       cpu_wr_n,
    input wire logic       cpu_rd_n,
    input wire logic       cpu_data_oe,
    input wire logic [7:0] chan_txd,
    input wire logic [7:0] chan_rxd,
    input wire logic [7:0] se_txd,
    input wire logic [7:0] diff_txd,
    input wire logic [7:0] diff_txd_oe,
    input wire logic       single_ended_driver_enable_n,
    input wire logic       differential_driver_enable,
    input wire logic       lamp_on,
    input wire logic       loopback_n,
    input wire logic       line_rx_enable
);
    logic [3:0] wr_gap_q;
    logic [3:0] rd_gap_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // clocks since the last write or read strobe, saturating
    always_ff @(posedge clk) begin
        wr_gap_q <= !rst_n ? 4'hf : !cpu_wr_n ? 4'h0 : wr_gap_q + {3'h0, wr_gap_q != 4'hf};
        rd_gap_q <= !rst_n ? 4'hf : !cpu_rd_n ? 4'h0 : rd_gap_q + {3'h0, rd_gap_q != 4'hf};
    end
    // a control level that has stood two clocks governs the line paths
    sequence s_two(x);
        x [*2];
    endsequence
    property p_se_mark;
        s_two(single_ended_driver_enable_n) |-> se_txd == 8'hff;
    endproperty
    a_se_mark: assert property (p_se_mark) else $error("se_txd not at mark");
    property p_se_pass;
        s_two(!single_ended_driver_enable_n) |-> se_txd == $past(chan_txd);
    endproperty
    a_se_pass: assert property (p_se_pass) else $error("se_txd not passing");
    property p_diff_on;
        s_two(differential_driver_enable) |-> diff_txd_oe == 8'hff;
    endproperty
    a_diff_on: assert property (p_diff_on) else $error("pairs not driven");
    property p_diff_off;
        s_two(!differential_driver_enable) |-> diff_txd_oe == 8'h00;
    endproperty
    a_diff_off: assert property (p_diff_off) else $error("pairs not floated");
    property p_diff_data;
        $past(rst_n) |-> diff_txd == $past(chan_txd);
    endproperty
    a_diff_data: assert property (p_diff_data) else $error("pair data wrong");
    property p_loop_route;
        s_two(!loopback_n) |-> chan_rxd == $past(chan_txd);
    endproperty
    a_loop_route: assert property (p_loop_route) else $error("no loopback");
    property p_rx_iso;
        s_two(!loopback_n) |-> !line_rx_enable;
    endproperty
    a_rx_iso: assert property (p_rx_iso) else $error("receivers on in loop");
    property p_reset;
        disable iff (1'h0) !rst_n |=> lamp_on && differential_driver_enable
            && single_ended_driver_enable_n && loopback_n && !cpu_data_oe;
    endproperty
    a_reset: assert property (p_reset) else $error("bad reset levels");
    property p_hold;
        !$stable({lamp_on, differential_driver_enable, single_ended_driver_enable_n,
                  loopback_n}) |-> wr_gap_q < 4'h8;
    endproperty
    a_hold: assert property (p_hold) else $error("control moved without write");
    property p_oe_rd;
        cpu_data_oe |-> rd_gap_q < 4'h6;
    endproperty
    a_oe_rd: assert property (p_oe_rd) else $error("data driven without read");
endmodule  // scl_decode_assertions

bind scl_decode scl_decode_assertions u_chk (
    .clk, .rst_n, .cpu_wr_n, .cpu_rd_n, .cpu_data_oe, .chan_txd, .chan_rxd, .se_txd,
    .diff_txd, .diff_txd_oe, .single_ended_driver_enable_n, .differential_driver_enable,
    .lamp_on, .loopback_n, .line_rx_enable);

// *** tb/scl_line_model.sv ***
// far-side model: differential pair wires and external receive lines
`timescale 1ns/1ns
module scl_line_model (
    input  wire logic [7:0] diff_txd,
    input  wire logic [7:0] diff_txd_oe,
    input  wire logic [7:0] rx_pat,
    output wire       [7:0] line_rxd,
    output wire       [7:0] diff_wire
);
    // a released pair floats, a driven pair carries the data
    for (genvar i = 0; i < 8; i++) begin : g_pair
        assign diff_wire[i] = diff_txd_oe[i] ? diff_txd[i] : 1'hz;
    end
    // receivers present the far-end line pattern
    assign line_rxd = rx_pat;
endmodule  // scl_line_model

// *** tb/serial_ctrl_line_decode_test.sv ***
// self-checking bench for the serial control line decoder
`timescale 1ns/1ns
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin mismatches++; \
    $display("[ERR] %s exp %h got %h", n, e, a); end end
module serial_ctrl_line_decode_test;
    import scl_pkg::*;
    typedef struct packed {logic [2:0] ch; scl_byte_type d; logic [3:0] x;} scl_row_type;
    logic         clk = 1'h0, rst_n = 1'h0, cpu_iorq_n = 1'h1, cpu_m1_n = 1'h1;
    logic         cpu_rd_n = 1'h1, cpu_wr_n = 1'h1;
    logic [2:0]   cpu_addr = 3'h0;
    scl_byte_type cpu_data_in = 8'h00, cpu_data_out, rd_q;
    logic [7:0]   chan_txd = 8'ha5, pat = 8'h3c, line_rxd, chan_rxd, se_txd, diff_txd;
    logic [7:0]   diff_txd_oe;
    logic         cpu_data_oe, single_ended_driver_enable_n, differential_driver_enable;
    logic         lamp_on, loopback_n, line_rx_enable;
    wire  [7:0]   dwire;
    int           mismatches = 0, checks = 0;
    // channel, transmit control byte, expected {se_n, diff, lamp, loop_n}
    scl_row_type  rows [10] = '{
        '{3'h0, 8'h02, 4'h7}, '{3'h1, 8'h80, 4'h3}, '{3'h1, 8'h02, 4'h5}, '{3'h3, 8'h02, 4'h5},
        '{3'h1, 8'h00, 4'h5}, '{3'h3, 8'h00, 4'h7}, '{3'h2, 8'hff, 4'h7}, '{3'h6, 8'hff, 4'h7},
        '{3'h0, 8'h80, 4'he}, '{3'h0, 8'h00, 4'hf}};
    // 20 MHz clock
    always #25 clk = ~clk;
    // design and far side
    scl_decode dut (.clk, .rst_n, .cpu_addr, .cpu_data_in, .cpu_data_out, .cpu_data_oe,
        .cpu_iorq_n, .cpu_rd_n, .cpu_wr_n, .cpu_m1_n, .chan_txd, .line_rxd, .chan_rxd,
        .se_txd, .diff_txd, .diff_txd_oe, .single_ended_driver_enable_n,
        .differential_driver_enable, .lamp_on, .loopback_n, .line_rx_enable);
    scl_line_model u_far (.diff_txd, .diff_txd_oe, .rx_pat(pat), .line_rxd,
        .diff_wire(dwire));
    task automatic tally_and_finish();
        $display("counts: %0d checks, %0d mismatches", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // one cpu strobe held until taken or answered, then four idle clocks
    task automatic cycle(input logic [2:0] a, input logic wr, input scl_byte_type d,
                         input logic m1_n);
        int n;
        @(posedge clk);
        cpu_addr    <= a;
        cpu_data_in <= d;
        cpu_iorq_n  <= 1'h0;
        cpu_m1_n    <= m1_n;
        cpu_wr_n    <= !wr;
        cpu_rd_n    <= wr;
        for (n = 0; n < 12; n++) begin
            @(posedge clk);
            if (n >= 3 && (wr || cpu_data_oe === 1'h1)) break;
        end
        if (n == 12) begin
            mismatches++;
            tally_and_finish();
        end
        rd_q = cpu_data_out;
        cpu_iorq_n <= 1'h1;
        cpu_wr_n   <= 1'h1;
        cpu_rd_n   <= 1'h1;
        cpu_m1_n   <= 1'h1;
        repeat (4) @(posedge clk);
    endtask
    // access a numbered register through the pointer
    task automatic acc(input logic [2:0] ch, input logic [2:0] r, input logic wr,
                       input scl_byte_type d);
        if (r != 3'h0) cycle(ch, 1'h1, {5'h00, r}, 1'h1);
        cycle(ch, wr, d, 1'h1);
    endtask
    // control lines and line paths against expected levels
    task automatic chk_lines(input logic [3:0] x);
        #1;
        `CHK("se_en_n", x[3], single_ended_driver_enable_n)
        `CHK("se_txd", x[3] ? 8'hff : chan_txd, se_txd)
        `CHK("diff_en", x[2], differential_driver_enable)
        `CHK("diff_wire", x[2] ? chan_txd : 8'hzz, dwire)
        `CHK("lamp_on", x[1], lamp_on)
        `CHK("loop_n", x[0], loopback_n)
        `CHK("rx_en", x[0], line_rx_enable)
        `CHK("chan_rxd", x[0] ? pat : chan_txd, chan_rxd)
        $display("test done: lines %h", x);
    endtask
    // reset, table of ordinary cases, then hand-written cases
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'h1;
        repeat (4) @(posedge clk);
        chk_lines(4'hf);
        foreach (rows[k]) begin
            chan_txd <= rows[k].d ^ 8'h5a;
            acc(rows[k].ch, 3'h5, 1'h1, rows[k].d);
            chk_lines(rows[k].x);
        end
        acc(3'h0, 3'h5, 1'h1, 8'h82);
        acc(3'h0, 3'h0, 1'h1, 8'h18);
        chk_lines(4'hf);
        acc(3'h0, 3'h6, 1'h1, 8'h82);
        acc(3'h0, 3'h7, 1'h1, 8'h82);
        chk_lines(4'hf);
        // an m1 pointer write is ignored, so the next byte sets pointer 2
        cycle(3'h0, 1'h1, 8'h05, 1'h0);
        cycle(3'h0, 1'h1, 8'h02, 1'h1);
        chk_lines(4'hf);
        cycle(3'h0, 1'h0, 8'h00, 1'h1);
        `CHK("rr2_chan_a", 8'h00, rd_q)
        acc(3'h1, 3'h2, 1'h1, 8'hf0);
        acc(3'h1, 3'h2, 1'h0, 8'h00);
        `CHK("rr2_chan_b", 8'hf6, rd_q)
        acc(3'h1, 3'h1, 1'h0, 8'h00);
        `CHK("rr1_sent", 1'h1, rd_q[0])
        acc(3'h0, 3'h0, 1'h0, 8'h00);
        `CHK("rr0_status", {pat[0], 1'h1}, {rd_q[4], rd_q[2]})
        acc(3'h0, 3'h5, 1'h0, 8'h00);
        `CHK("rr5_zero", 8'h00, rd_q)
        $display("test done: register reads");
        // every control line driven low, then a reset in mid-run
        acc(3'h1, 3'h5, 1'h1, 8'h82);
        acc(3'h0, 3'h5, 1'h1, 8'h82);
        chk_lines(4'h0);
        rst_n <= 1'h0;
        repeat (3) @(posedge clk);
        rst_n <= 1'h1;
        repeat (4) @(posedge clk);
        chk_lines(4'hf);
        tally_and_finish();
    end
endmodule  // serial_ctrl_line_decode_test
